/* design/purge_consts.svh */
// offsets, field positions, reset values and timing counts of the purge supervisor
// assumes a 200 MHz system clock and a 32-bit register bus
`ifndef PURGE_CONSTS_SVH
`define PURGE_CONSTS_SVH

// timing
`define CLK_MHZ 200
`define TICK_US 1000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define DEBOUNCE_US 10
`define DEBOUNCE_CYCLES (`DEBOUNCE_US * `CLK_MHZ)
`define STANDBY_HOURS 24
`define STANDBY_TICKS (`STANDBY_HOURS * 3600 * (1000 / `TICK_US) * 1000)

// register offsets
`define OFS_CFG 8'h00
`define OFS_PRE_BASE 8'h04
`define OFS_PRE_MULT 8'h08
`define OFS_POST_BASE 8'h0c
`define OFS_POST_MULT 8'h10
`define OFS_CTRL 8'h14
`define OFS_STATUS 8'h18

// field widths and positions
`define BASE_W 24
`define MULT_W 8
`define CFG_W 7
`define STATUS_W 15
`define CTRL_UNLOCK 0

// reset values: closure mode 1, prepurge on every start
`define RST_CFG 7'h11
`define RST_PRE_BASE 24'h0071b2
`define RST_PRE_MULT 8'h01
`define RST_POST_BASE 24'h000000
`define RST_POST_MULT 8'h01

// phase and lockout codes
`define PH_MIN_GAS 8'h1e
`define LOCK_CLOSURE 8'h0e
`define LOCK_MIN_GAS 8'h14
`define LOCK_MAX_GAS 8'h15

`endif

/* design/purge_pkg.sv */
// types shared by the purge supervisor and its bench
// assumes nothing beyond a SystemVerilog tool
package purge_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PRE = 3'b010,
		ST_POST = 3'b100
	} purge_state_t;

	// layout equals the config register, bit 6 down to bit 0
	typedef struct packed {
		logic vp_en;
		logic [1:0] closure_mode;
		logic func_sel;
		logic gas_eval;
		logic gas_resp;
		logic pre_en;
	} cfg_t;

	// layout equals the status register, bit 14 down to bit 0
	typedef struct packed {
		logic func_in;
		logic gas_min_ok;
		logic force_pre;
		logic post_act;
		logic pre_act;
		logic prevent;
		logic lock;
		logic [7:0] code;
	} status_t;

	// sequencer view, same clock domain
	typedef struct packed {
		logic [7:0] phase;
		logic safety_time;
		logic in_operation;
		logic second_interval;
		logic closure_window;
		logic to_operation;
		logic start_req;
		logic shutdown_req;
	} seq_t;

	// raw field switches, 1 = contact closed
	typedef struct packed {
		logic gas_min_ok;
		logic func_in;
	} field_t;

endpackage : purge_pkg

/* design/switch_debounce.sv */
// two-flop synchroniser plus stability filter, one lane per switch
// assumes raw inputs are asynchronous contacts
`timescale 1ns/10ps
`include "purge_consts.svh"

module switch_debounce #(
	parameter int unsigned WIDTH = 2,
	parameter int unsigned STABLE_CYCLES = `DEBOUNCE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// switches
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean
);
	localparam int CW = $clog2(STABLE_CYCLES + 1);

	if (WIDTH < 1 || STABLE_CYCLES < 1) begin : g_bad
		$error("switch_debounce: bad parameters");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_lane
		logic s1;
		logic s2;
		logic q;
		logic [CW-1:0] cnt;
		// s1 feeds only s2
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				q <= 1'b0;
				cnt <= '0;
			end else begin
				s1 <= raw[i];
				s2 <= s1;
				if (s2 == q) begin
					cnt <= '0;
				end else if (cnt == CW'(STABLE_CYCLES - 1)) begin
					q <= s2;
					cnt <= '0;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
		assign clean[i] = q;
	end
endmodule : switch_debounce

/* design/burner_purge_input_supervisor.sv */
// purge timing and gas / closure input supervision of a burner sequencer
// assumes an ahb-lite master on hclk and a sequencer on the same clock
`timescale 1ns/10ps
`include "purge_consts.svh"

module burner_purge_input_supervisor #(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
	parameter int unsigned STANDBY_TICKS = `STANDBY_TICKS
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// sequencer
	input purge_pkg::seq_t seq,
	// field switches
	input purge_pkg::field_t field_raw,
	// purge results
	output logic prepurge_active,
	output logic postpurge_active,
	output logic prepurge_done,
	output logic postpurge_done,
	// supervision results
	output logic safety_shutdown,
	output logic start_prevention,
	output logic restart_req,
	output logic yellow_lamp,
	output logic safety_loop_active,
	output logic lockout,
	output logic [7:0] lockout_code
);
	import purge_pkg::*;

	if (TICK_CYCLES < 2 || DEBOUNCE_CYCLES < 1 || STANDBY_TICKS < 1) begin : g_bad
		$error("burner_purge_input_supervisor: bad parameters");
	end

	// tick divider
	// one-cycle enable every TICK_CYCLES clocks; all purge timing counts it
	logic [31:0] div_cnt;
	logic tick;
	wire div_wrap = div_cnt == 32'(TICK_CYCLES - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= 32'h0;
			tick <= 1'b0;
		end else begin
			div_cnt <= div_wrap ? 32'h0 : div_cnt + 32'h1;
			tick <= div_wrap;
		end
	end

	// clean field switches
	// contacts read open until the filter has seen them stable
	field_t field;
	switch_debounce #(
		.WIDTH(2),
		.STABLE_CYCLES(DEBOUNCE_CYCLES)
	) u_debounce (
		.clk(hclk),
		.rst_n(hresetn),
		.raw(field_raw),
		.clean(field)
	);

	// registers
	// cfg keeps the register layout, so a write is a plain copy
	cfg_t cfg;
	logic [`BASE_W-1:0] pre_base;
	logic [`MULT_W-1:0] pre_mult;
	logic [`BASE_W-1:0] post_base;
	logic [`MULT_W-1:0] post_mult;
	logic force_pre;
	logic prevent;
	purge_state_t state;
	logic [31:0] timer;
	logic [31:0] standby_cnt;

	// bus decode; the slave never waits, so data phase follows address phase
	wire addr_phase = hsel & htrans[1] & hready;
	logic wr_pend;
	logic [7:0] wr_addr;
	wire wr_cfg = wr_pend && wr_addr == `OFS_CFG;
	wire wr_pre_base = wr_pend && wr_addr == `OFS_PRE_BASE;
	wire wr_pre_mult = wr_pend && wr_addr == `OFS_PRE_MULT;
	wire wr_post_base = wr_pend && wr_addr == `OFS_POST_BASE;
	wire wr_post_mult = wr_pend && wr_addr == `OFS_POST_MULT;
	wire wr_ctrl = wr_pend && wr_addr == `OFS_CTRL;
	wire unlock_req = wr_ctrl & hwdata[`CTRL_UNLOCK];

	status_t status;
	assign status = '{
		func_in: field.func_in,
		gas_min_ok: field.gas_min_ok,
		force_pre: force_pre,
		post_act: postpurge_active,
		pre_act: prepurge_active,
		prevent: prevent,
		lock: lockout,
		code: lockout_code
	};

	wire [7:0] rd_addr = haddr[7:0];
	wire [31:0] rd_word =
		(rd_addr == `OFS_CFG) ? 32'(cfg) :
		(rd_addr == `OFS_PRE_BASE) ? 32'(pre_base) :
		(rd_addr == `OFS_PRE_MULT) ? 32'(pre_mult) :
		(rd_addr == `OFS_POST_BASE) ? 32'(post_base) :
		(rd_addr == `OFS_POST_MULT) ? 32'(post_mult) :
		(rd_addr == `OFS_STATUS) ? 32'(status) : 32'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= addr_phase & hwrite;
			if (addr_phase) begin
				wr_addr <= rd_addr;
			end
			// zero outside a read data phase, so no stale word shows
			hrdata <= (addr_phase & ~hwrite) ? rd_word : 32'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg <= `RST_CFG;
			pre_base <= `RST_PRE_BASE;
			pre_mult <= `RST_PRE_MULT;
			post_base <= `RST_POST_BASE;
			post_mult <= `RST_POST_MULT;
		end else begin
			if (wr_cfg) cfg <= hwdata[`CFG_W-1:0];
			if (wr_pre_base) pre_base <= hwdata[`BASE_W-1:0];
			if (wr_pre_mult) pre_mult <= hwdata[`MULT_W-1:0];
			if (wr_post_base) post_base <= hwdata[`BASE_W-1:0];
			if (wr_post_mult) post_mult <= hwdata[`MULT_W-1:0];
		end
	end

	// 32-bit product covers the 1188 h range
	wire [31:0] pre_ticks = 32'(pre_base) * 32'(pre_mult);
	wire [31:0] post_ticks = 32'(post_base) * 32'(post_mult);
	wire post_zero = post_ticks == 32'h0;

	// from phase 30 outside both safety times
	wire gas_win_perm = (seq.phase >= `PH_MIN_GAS) & ~seq.safety_time;
	wire gas_window = cfg.gas_eval ? seq.in_operation : gas_win_perm;
	wire gas_loss = gas_window & ~field.gas_min_ok & ~lockout;
	wire gas_shutdown = gas_loss & ~cfg.gas_resp & ~prevent;
	wire gas_lock = gas_loss & cfg.gas_resp;

	// shared input goes to at most one function; with func_sel 0, closure mode 0 leaves it unused
	wire closure_sel = ~cfg.func_sel;
	wire max_sel = cfg.func_sel;
	wire closure_on = closure_sel & (cfg.closure_mode != 2'd0);
	// must be closed in startup and shutdown
	wire closure_bad_closed = seq.closure_window & ~field.func_in;
	// must have opened on switching to operation
	wire closure_bad_open = (cfg.closure_mode == 2'd2) & seq.to_operation & field.func_in;
	// wrong contact state in a checked phase
	wire closure_lock = closure_on & (closure_bad_closed | closure_bad_open);
	// watched from the second interval on
	wire max_watch = max_sel & seq.second_interval;
	wire max_lock = max_watch & ~field.func_in;

	wire fault = ~lockout & (gas_lock | max_lock | closure_lock);
	wire [7:0] fault_code =
		gas_lock ? `LOCK_MIN_GAS :
		max_lock ? `LOCK_MAX_GAS : `LOCK_CLOSURE;

	// lockout; faults are masked while locked, so an unlock write clears it even with a fault present
	// safety loop follows next_lockout, so both flops change together
	wire next_lockout = fault | (lockout & ~unlock_req);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lockout <= 1'b0;
			lockout_code <= 8'h0;
			safety_loop_active <= 1'b1;
		end else begin
			lockout <= next_lockout;
			if (fault) lockout_code <= fault_code;
			else if (unlock_req) lockout_code <= 8'h0;
			safety_loop_active <= ~next_lockout;
		end
	end

	// prevention holds until gas returns, then restarts
	wire gas_back = prevent & field.gas_min_ok;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prevent <= 1'b0;
			start_prevention <= 1'b0;
			yellow_lamp <= 1'b0;
			safety_shutdown <= 1'b0;
			restart_req <= 1'b0;
		end else begin
			prevent <= gas_shutdown | (prevent & ~gas_back);
			start_prevention <= gas_shutdown | (prevent & ~gas_back);
			yellow_lamp <= gas_shutdown | (prevent & ~gas_back);
			safety_shutdown <= gas_shutdown;
			restart_req <= gas_back;
		end
	end

	// purge sequencing
	wire stop = lockout | prevent;
	wire start_ok = seq.start_req & ~stop;
	wire shut_ok = seq.shutdown_req & ~stop;
	wire need_pre = cfg.pre_en | force_pre | (cfg.vp_en & post_zero);
	wire last_tick = tick & (timer <= 32'h1);
	wire pre_end = (state == ST_PRE) & last_tick & ~stop;
	wire pre_skip = (state == ST_IDLE) & start_ok & (~need_pre | pre_ticks == 32'h0);
	wire post_end = (state == ST_POST) & last_tick & ~stop;
	wire post_skip = (state == ST_IDLE) & ~start_ok & shut_ok & post_zero;

	purge_state_t next_state;
	logic [31:0] next_timer;
	always_comb begin
		next_state = state;
		next_timer = timer;
		case (state)
			ST_IDLE: begin
				if (start_ok && need_pre && pre_ticks != 32'h0) begin
					next_state = ST_PRE;
					next_timer = pre_ticks;
				end else if (shut_ok && !start_ok && !post_zero) begin
					next_state = ST_POST;
					next_timer = post_ticks;
				end
			end
			ST_PRE, ST_POST: begin
				// count down one tick at a time
				// the first tick may come at once: a purge lasts N-1 to N ticks
				if (stop || last_tick) begin
					next_state = ST_IDLE;
					next_timer = 32'h0;
				end else if (tick) begin
					next_timer = timer - 32'h1;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_timer = 32'h0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
			timer <= 32'h0;
			prepurge_active <= 1'b0;
			postpurge_active <= 1'b0;
			prepurge_done <= 1'b0;
			postpurge_done <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			prepurge_active <= next_state == ST_PRE;
			postpurge_active <= next_state == ST_POST;
			prepurge_done <= pre_end | pre_skip;
			postpurge_done <= post_end | post_skip;
		end
	end

	// standby clock, only while idle and free to start
	// any purge, lockout or prevention restarts the count
	wire standby = (state == ST_IDLE) & ~stop;
	wire standby_full = standby & tick & (standby_cnt == 32'(STANDBY_TICKS - 1));

	// sticky demand; any new cause wins over the clear
	// an unlock write sets the demand only while a lockout stands
	wire force_set = standby_full | gas_shutdown | (lockout & unlock_req & ~fault);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// power-up always demands a purge
			force_pre <= 1'b1;
			standby_cnt <= 32'h0;
		end else begin
			force_pre <= force_set | (force_pre & ~pre_end);
			if (!standby || standby_full) standby_cnt <= 32'h0;
			else if (tick) standby_cnt <= standby_cnt + 32'h1;
		end
	end

	// hsize unused: only whole-word transfers exist on this bus
	wire unused_ok = &{1'b0, hsize, haddr[31:8], htrans[0]};

endmodule : burner_purge_input_supervisor

/* verification/field_switches.sv */
// model of the burner field contacts: gas pressure and shared function input
// assumes the bench commands each contact level just after a rising clock edge
`timescale 1ns/10ps

module field_switches
import purge_pkg::*;
(
	// clock
	input wire logic hclk,
	// commanded contact levels, 1 = closed
	input wire logic gas_closed,
	input wire logic func_closed,
	// contacts as seen at the pins
	output purge_pkg::field_t field_raw
);
	logic [1:0] last;
	logic [1:0] older;

	// a real contact chatters: one cycle of the old level after each change
	always @(posedge hclk) begin
		last <= {gas_closed, func_closed};
		older <= last;
	end
	assign field_raw = {gas_closed, func_closed} ^ (last ^ older);
endmodule : field_switches

/* verification/purge_monitor.sv */
// concurrent checks on the purge supervisor outputs
// assumes one clock domain, hresetn asynchronous and active low
`timescale 1ns/10ps

module purge_monitor
import purge_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// sequencer
	input purge_pkg::seq_t seq,
	// results
	input wire logic prepurge_active,
	input wire logic postpurge_active,
	input wire logic prepurge_done,
	input wire logic safety_shutdown,
	input wire logic start_prevention,
	input wire logic restart_req,
	input wire logic yellow_lamp,
	input wire logic safety_loop_active,
	input wire logic lockout,
	input wire logic [7:0] lockout_code
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_loop_lock: assert property (safety_loop_active == !lockout)
		else $error("safety loop level wrong");
	chk_lamp_prev: assert property (yellow_lamp == start_prevention)
		else $error("lamp differs from prevention");
	chk_prev_shut: assert property ($rose(start_prevention) |-> safety_shutdown)
		else $error("prevention without shutdown");
	chk_prev_window: assert property ($rose(start_prevention) |->
		$past(seq.phase) >= 8'h1e || $past(seq.in_operation))
		else $error("prevention outside window");
	chk_code_held: assert property (lockout && $past(lockout) |-> $stable(lockout_code))
		else $error("lockout code changed");
	chk_lock_code: assert property ($rose(lockout) |->
		lockout_code inside {8'h0e, 8'h14, 8'h15})
		else $error("bad lockout code");
	chk_max_window: assert property ($rose(lockout) && lockout_code == 8'h15 |->
		$past(seq.second_interval))
		else $error("max gas fault outside interval");
	chk_pre_done: assert property ($fell(prepurge_active) && !lockout &&
		!start_prevention |-> prepurge_done)
		else $error("prepurge ended without done");
	chk_done_pulse: assert property (prepurge_done |-> !prepurge_active ##1 !prepurge_done)
		else $error("done not a single pulse");
	chk_pre_start: assert property ($rose(prepurge_active) |-> $past(seq.start_req))
		else $error("prepurge without start");
	chk_lock_stops: assert property (lockout |=> !prepurge_active && !postpurge_active)
		else $error("purge runs in lockout");

	cov_lock: cover property ($rose(lockout));
	cov_pre: cover property ($fell(prepurge_active));
	cov_restart: cover property (restart_req);
endmodule : purge_monitor

bind burner_purge_input_supervisor purge_monitor u_mon (
	.hclk(hclk), .hresetn(hresetn), .seq(seq),
	.prepurge_active(prepurge_active), .postpurge_active(postpurge_active),
	.prepurge_done(prepurge_done), .safety_shutdown(safety_shutdown),
	.start_prevention(start_prevention), .restart_req(restart_req),
	.yellow_lamp(yellow_lamp), .safety_loop_active(safety_loop_active),
	.lockout(lockout), .lockout_code(lockout_code)
);

/* verification/tb_top.sv */
// self-checking bench of the purge supervisor with short tick and debounce counts
// assumes the field_switches model and the bound monitor
`timescale 1ns/10ps

module tb_top;
	import purge_pkg::*;
	logic hclk, hresetn, hsel, hwrite, gas_cmd, func_cmd, shut_seen, rst_seen;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	seq_t seq;
	field_t field_raw;
	wire hreadyout, hresp, pre_act, post_act, pre_done, post_done;
	wire shut, prev, restart, lamp, loop_ok, lock;
	wire [31:0] hrdata;
	wire [7:0] code;
	int errors, cmp_count, act, dn;

	burner_purge_input_supervisor #(.TICK_CYCLES(4), .DEBOUNCE_CYCLES(2),
		.STANDBY_TICKS(20)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .seq(seq),
		.field_raw(field_raw), .prepurge_active(pre_act), .postpurge_active(post_act),
		.prepurge_done(pre_done), .postpurge_done(post_done), .safety_shutdown(shut),
		.start_prevention(prev), .restart_req(restart), .yellow_lamp(lamp),
		.safety_loop_active(loop_ok), .lockout(lock), .lockout_code(code));
	field_switches u_sw (.hclk(hclk), .gas_closed(gas_cmd), .func_closed(func_cmd),
		.field_raw(field_raw));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (shut) shut_seen <= 1'b1;
		if (restart) rst_seen <= 1'b1;
	end

	task final_report;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task idle(input int n);
		repeat (n) @(posedge hclk);
	endtask : idle
	// bounded wait for hready sampled high
	task rdy_wait;
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			i = i + 1;
			if (i > 50) begin
				errors++;
				final_report;
			end
			@(posedge hclk);
		end
	endtask : rdy_wait
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy_wait;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy_wait;
		rd = hrdata;
	endtask : bus
	task lock_is(input logic [9:0] exp);
		chk({22'h0, lock, loop_ok, code}, {22'h0, exp});
	endtask : lock_is
	// one purge request; counts active cycles until done or bound
	task purge(input logic post);
		int i;
		act = 0;
		dn = 0;
		if (post) seq.shutdown_req <= 1'b1;
		else seq.start_req <= 1'b1;
		for (i = 0; i < 200 && dn == 0; i++) begin
			@(posedge hclk);
			seq.start_req <= 1'b0;
			seq.shutdown_req <= 1'b0;
			if (post ? post_act : pre_act) act++;
			if (post ? post_done : pre_done) dn = 1;
		end
	endtask : purge

	task t_regs;
		bus(1'b0, 8'h00, 32'h0); chk(rd, 32'h11);
		chk(32'({hreadyout, hresp}), 32'h2);
		bus(1'b0, 8'h04, 32'h0); chk(rd, 32'h71b2);
		bus(1'b0, 8'h08, 32'h0); chk(rd, 32'h1);
		bus(1'b0, 8'h0c, 32'h0); chk(rd, 32'h0);
		bus(1'b0, 8'h10, 32'h0); chk(rd, 32'h1);
		bus(1'b1, 8'h04, 32'hffffffff); bus(1'b0, 8'h04, 32'h0); chk(rd, 32'hffffff);
		bus(1'b1, 8'h1c, 32'hff); bus(1'b0, 8'h1c, 32'h0); chk(rd, 32'h0);
	endtask : t_regs
	task t_timing;
		bus(1'b1, 8'h04, 32'h3); bus(1'b1, 8'h08, 32'h2);
		purge(1'b0); chk(32'(act > 20 && act < 29 && dn == 1), 32'h1);
		bus(1'b1, 8'h0c, 32'h2);
		purge(1'b1); chk(32'(act > 4 && act < 13 && dn == 1), 32'h1);
	endtask : t_timing
	task t_skip;
		bus(1'b1, 8'h00, 32'h10);
		purge(1'b0); chk(32'({act == 0, dn == 1}), 32'h3);
		bus(1'b1, 8'h0c, 32'h0);
		purge(1'b1); chk(32'({act == 0, dn == 1}), 32'h3);
		bus(1'b1, 8'h00, 32'h50);
		purge(1'b0); chk(32'(act > 20), 32'h1);
		bus(1'b1, 8'h00, 32'h10);
		bus(1'b0, 8'h18, 32'h0); chk(32'(rd[12]), 32'h0);
		idle(90);
		bus(1'b0, 8'h18, 32'h0); chk(32'(rd[12]), 32'h1);
	endtask : t_skip
	task t_gas_eval;
		bus(1'b1, 8'h00, 32'h14);
		seq.phase <= 8'h28;
		gas_cmd <= 1'b0;
		idle(12); chk(32'({lock, prev}), 32'h0);
		seq.in_operation <= 1'b1;
		idle(4); chk(32'({lock, prev}), 32'h1);
		seq.in_operation <= 1'b0;
		gas_cmd <= 1'b1;
		idle(12); chk(32'(prev), 32'h0);
		bus(1'b1, 8'h00, 32'h10);
		seq.safety_time <= 1'b1;
		gas_cmd <= 1'b0;
		idle(12); chk(32'({lock, prev}), 32'h0);
		gas_cmd <= 1'b1;
		idle(12);
		// close the safety time only once the contact reads closed again
		seq.safety_time <= 1'b0;
		idle(2);
	endtask : t_gas_eval
	task t_gas_prev;
		seq.phase <= 8'h1e;
		shut_seen <= 1'b0;
		rst_seen <= 1'b0;
		gas_cmd <= 1'b0;
		idle(12); chk(32'({shut_seen, prev, lamp, loop_ok, lock}), 32'h1e);
		bus(1'b0, 8'h18, 32'h0); chk(32'(rd[12]), 32'h1);
		purge(1'b0); chk(32'(act), 32'h0);
		gas_cmd <= 1'b1;
		idle(12); chk(32'({rst_seen, prev, lamp}), 32'h4);
		purge(1'b0); chk(32'(act > 20), 32'h1);
	endtask : t_gas_prev
	task t_gas_lock;
		bus(1'b1, 8'h00, 32'h12);
		gas_cmd <= 1'b0;
		idle(12); lock_is({2'b10, 8'h14});
		gas_cmd <= 1'b1;
		seq.phase <= 8'h00;
		idle(12);
		bus(1'b1, 8'h14, 32'h1);
		idle(2); chk(32'(lock), 32'h0);
		bus(1'b0, 8'h18, 32'h0); chk(32'(rd[12]), 32'h1);
	endtask : t_gas_lock
	task t_max_gas;
		bus(1'b1, 8'h00, 32'h18);
		seq.closure_window <= 1'b1;
		func_cmd <= 1'b0;
		idle(12); chk(32'(lock), 32'h0);
		seq.second_interval <= 1'b1;
		idle(4); lock_is({2'b10, 8'h15});
		func_cmd <= 1'b1;
		seq.second_interval <= 1'b0;
		seq.closure_window <= 1'b0;
		idle(12);
		bus(1'b1, 8'h14, 32'h1);
	endtask : t_max_gas
	task t_closure;
		bus(1'b1, 8'h00, 32'h00);
		seq.closure_window <= 1'b1;
		func_cmd <= 1'b0;
		idle(12); chk(32'(lock), 32'h0);
		bus(1'b1, 8'h00, 32'h10);
		idle(4); lock_is({2'b10, 8'h0e});
		func_cmd <= 1'b1;
		seq.closure_window <= 1'b0;
		idle(12);
		bus(1'b1, 8'h14, 32'h1);
		bus(1'b1, 8'h00, 32'h20);
		seq.to_operation <= 1'b1;
		@(posedge hclk);
		seq.to_operation <= 1'b0;
		idle(4); lock_is({2'b10, 8'h0e});
	endtask : t_closure
	// power cycle in mid-run, with a lockout standing
	task t_reset;
		hresetn <= 1'b0;
		idle(2);
		hresetn <= 1'b1;
		bus(1'b0, 8'h18, 32'h0); chk(32'({rd[12], rd[8]}), 32'h2);
		bus(1'b0, 8'h00, 32'h0); chk(rd, 32'h11);
	endtask : t_reset

	initial begin
		errors = 0;
		cmp_count = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		seq = '0;
		gas_cmd = 1'b1;
		func_cmd = 1'b1;
		shut_seen = 1'b0;
		rst_seen = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_timing;
		t_skip;
		t_gas_eval;
		t_gas_prev;
		t_gas_lock;
		t_max_gas;
		t_closure;
		t_reset;
		final_report;
	end
endmodule : tb_top
